// File: rtl/arbl_bank.sv
// module: read-only result byte bank with high/low coherence locks
// assumes converter result strobes come from logic on aclk; AXI4-Lite host
`timescale 1ns/1ps
module arbl_bank
  import arbl_pkg::*;
#(
  parameter int ADDR_W     = 16,
  parameter int CELL_COUNT = 6
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              general_input_eight_valid,
  input  wire logic [15:0]       general_input_eight_result,
  input  wire logic              die_temp_main_valid,
  input  wire logic [15:0]       die_temp_main_result,
  input  wire logic              die_temp_aux_valid,
  input  wire logic [15:0]       die_temp_aux_result,
  input  wire logic              redundant_cell_voltage_valid,
  input  wire logic [15:0]       redundant_cell_voltage_result,
  output logic [4:0]             redundant_channel_select
);

  // pair order: 0 input eight, 1 main die, 2 aux die, 3 cell voltage
  logic [ARBL_PAIRS-1:0] upd;
  logic [15:0]           upd_data [ARBL_PAIRS];
  logic [11:0]           hi_idx   [ARBL_PAIRS];
  logic [15:0]           live_r   [ARBL_PAIRS];
  logic [7:0]            hold_r   [ARBL_PAIRS];
  logic [ARBL_PAIRS-1:0] lock_r;
  logic [ARBL_PAIRS-1:0] rd_hi;
  logic [ARBL_PAIRS-1:0] rd_lo;
  logic                  sel_single;
  logic                  ar_take;
  logic [11:0]           ar_idx;
  logic [11:0]           aw_idx;

  // bus channel registers and next values
  logic                  aw_hold_r;
  logic                  aw_hold_nxt;
  logic [11:0]           aw_idx_r;
  logic [11:0]           aw_idx_nxt;
  logic                  w_hold_r;
  logic                  w_hold_nxt;
  logic [31:0]           w_data_r;
  logic [31:0]           w_data_nxt;
  logic                  w_strb0_r;
  logic                  w_strb0_nxt;
  logic                  awready_r;
  logic                  awready_nxt;
  logic                  wready_r;
  logic                  wready_nxt;
  logic                  bvalid_r;
  logic                  bvalid_nxt;
  logic [1:0]            bresp_r;
  logic [1:0]            bresp_nxt;
  logic                  arready_r;
  logic                  arready_nxt;
  logic                  rvalid_r;
  logic                  rvalid_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic [1:0]            rresp_r;
  logic [1:0]            rresp_nxt;
  logic [4:0]            sel_r;
  logic [4:0]            sel_nxt;

  // single-channel select codes are 1..CELL_COUNT
  assign sel_single = (sel_r != 5'h00) &&
                      (32'(sel_r) <= 32'(CELL_COUNT));

  assign upd[0]      = general_input_eight_valid;
  assign upd_data[0] = general_input_eight_result;

  assign upd[1]      = die_temp_main_valid;
  assign upd_data[1] = die_temp_main_result;

  assign upd[2]      = die_temp_aux_valid;
  assign upd_data[2] = die_temp_aux_result;

  // signed word stored as is: high byte = bits 15:8
  assign upd[3]      = redundant_cell_voltage_valid && sel_single;
  assign upd_data[3] = redundant_cell_voltage_result;

  assign hi_idx[0]   = IDX_GIN8_HI;
  assign hi_idx[1]   = IDX_DIE_MAIN_HI;
  assign hi_idx[2]   = IDX_DIE_AUX_HI;
  assign hi_idx[3]   = IDX_CELL_HI;

  assign ar_take = s_axi_arvalid && arready_r;
  assign ar_idx  = s_axi_araddr[2 +: ARBL_IDX_W];
  assign aw_idx  = s_axi_awaddr[2 +: ARBL_IDX_W];

  // per-pair result storage and low-byte freeze
  for (genvar i = 0; i < ARBL_PAIRS; i++) begin : g_pair
    logic [15:0] live_nxt;
    logic [7:0]  hold_nxt;
    logic        lock_nxt;

    // low byte sits at the index after its high byte
    assign rd_hi[i] = ar_take && (ar_idx == hi_idx[i]);
    assign rd_lo[i] = ar_take && (ar_idx == hi_idx[i] + 12'h001);

    always_comb begin
      live_nxt = upd[i] ? upd_data[i] : live_r[i];
      hold_nxt = hold_r[i];
      lock_nxt = lock_r[i];
      // high read snapshots low and freezes it
      if (rd_hi[i]) begin
        hold_nxt = live_r[i][7:0];
        lock_nxt = 1'b1;
      end else if (rd_lo[i]) begin
        lock_nxt = 1'b0; // both bytes read: release
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        live_r[i] <= {RST_HI, RST_LO};
        hold_r[i] <= RST_LO;
        lock_r[i] <= 1'b0;
      end else begin
        live_r[i] <= live_nxt;
        hold_r[i] <= hold_nxt;
        lock_r[i] <= lock_nxt;
      end
    end
  end

  // low byte as the host sees it: snapshot while locked
  function automatic logic [7:0] lo_view(input int k);
    lo_view = lock_r[k] ? hold_r[k] : live_r[k][7:0];
  endfunction

  // write channel: address and data taken in either order
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_idx_nxt  = aw_idx_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb0_nxt = w_strb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    sel_nxt     = sel_r;

    if (s_axi_awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      aw_idx_nxt  = aw_idx;
    end

    if (s_axi_wvalid && wready_r) begin
      w_hold_nxt  = 1'b1;
      w_data_nxt  = s_axi_wdata;
      w_strb0_nxt = s_axi_wstrb[0];
    end

    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end

    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      unique case (aw_idx_r)
        IDX_CTRL: begin
          if (w_strb0_r) begin
            sel_nxt = w_data_r[CTRL_SEL_LSB +: CTRL_SEL_W];
          end
        end
        // result bytes: write dropped, no lock change
        IDX_GIN8_HI,
        IDX_GIN8_LO,
        IDX_DIE_MAIN_HI,
        IDX_DIE_MAIN_LO,
        IDX_DIE_AUX_HI,
        IDX_DIE_AUX_LO,
        IDX_CELL_HI,
        IDX_CELL_LO: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_DECERR;
      endcase
    end

    awready_nxt = !aw_hold_nxt;
    wready_nxt  = !w_hold_nxt;
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_idx_r  <= 12'h000;
      w_hold_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      sel_r     <= RST_SEL;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_hold_r  <= w_hold_nxt;
      w_data_r  <= w_data_nxt;
      w_strb0_r <= w_strb0_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      sel_r     <= sel_nxt;
    end
  end

  // read channel: one read in flight, answer the edge after the take
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;

    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end

    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      unique case (ar_idx)
        IDX_GIN8_HI:     rdata_nxt[7:0] = live_r[0][15:8];
        IDX_GIN8_LO:     rdata_nxt[7:0] = lo_view(0);
        IDX_DIE_MAIN_HI: rdata_nxt[7:0] = live_r[1][15:8];
        IDX_DIE_MAIN_LO: rdata_nxt[7:0] = lo_view(1);
        IDX_DIE_AUX_HI:  rdata_nxt[7:0] = live_r[2][15:8];
        IDX_DIE_AUX_LO:  rdata_nxt[7:0] = lo_view(2);
        IDX_CELL_HI:     rdata_nxt[7:0] = live_r[3][15:8];
        IDX_CELL_LO:     rdata_nxt[7:0] = lo_view(3);
        IDX_CTRL: begin
          rdata_nxt[CTRL_SEL_LSB +: CTRL_SEL_W] = sel_r;
          rdata_nxt[CTRL_LOCK_LSB +: ARBL_PAIRS] = lock_r;
        end
        default: rresp_nxt = RESP_DECERR;
      endcase
    end

    arready_nxt = !rvalid_nxt;
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // outputs driven straight from registers
  assign s_axi_awready            = awready_r;
  assign s_axi_wready             = wready_r;
  assign s_axi_bvalid             = bvalid_r;
  assign s_axi_bresp              = bresp_r;
  assign s_axi_arready            = arready_r;
  assign s_axi_rvalid             = rvalid_r;
  assign s_axi_rdata              = rdata_r;
  assign s_axi_rresp              = rresp_r;
  assign redundant_channel_select = sel_r;

endmodule

// File: rtl/arbl_pkg.sv
// package: register indices, reset values and bus codes of the result bank
// assumes byte address = 4 * register index, 32-bit data words
package arbl_pkg;
  localparam int          ARBL_PAIRS       = 4;
  localparam int          ARBL_IDX_W       = 12;
  // printed offsets kept as register indices
  localparam logic [11:0] IDX_GIN8_HI      = 12'h59C;
  localparam logic [11:0] IDX_GIN8_LO      = 12'h59D;
  localparam logic [11:0] IDX_DIE_MAIN_HI  = 12'h5AE;
  localparam logic [11:0] IDX_DIE_MAIN_LO  = 12'h5AF;
  localparam logic [11:0] IDX_DIE_AUX_HI   = 12'h5B0;
  localparam logic [11:0] IDX_DIE_AUX_LO   = 12'h5B1;
  localparam logic [11:0] IDX_CELL_HI      = 12'h5B2;
  localparam logic [11:0] IDX_CELL_LO      = 12'h5B3;
  localparam logic [11:0] IDX_CTRL         = 12'h5C0;
  // control word fields
  localparam int          CTRL_SEL_LSB     = 0;
  localparam int          CTRL_SEL_W       = 5;
  localparam int          CTRL_LOCK_LSB    = 8;
  // reset values
  localparam logic [7:0]  RST_HI           = 8'h80;
  localparam logic [7:0]  RST_LO           = 8'h00;
  localparam logic [4:0]  RST_SEL          = 5'h00;
  // bus answers
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_DECERR      = 2'h3;
endpackage

// File: tb/arbl_bank_chk.sv
// checker: bus timing and data shape of the result bank
// assumes bind onto arbl_bank, one clock
`timescale 1ns/1ps
module arbl_bank_chk
  import arbl_pkg::*;
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [1:0]  s_axi_rresp,
  input logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp moved");
  chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_aw_once: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("address taken twice");
  chk_byte_wide: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_OKAY |-> s_axi_rdata[31:12] == 20'h0)
    else $error("wide data");
  chk_decerr_zero: assert property (s_axi_rvalid && s_axi_rresp ==
    RESP_DECERR |-> s_axi_rdata == 32'h0) else $error("decerr data");
  chk_bresp_code: assert property (
    s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_DECERR)
    else $error("bad bresp");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
endmodule
bind arbl_bank arbl_bank_chk arbl_bank_chk_inst (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata));

// File: tb/adc_result_byte_lock_bank_test.sv
// testbench: result reads, low-byte locks, refused writes
// assumes arbl_bank with default parameters, CELL_COUNT 6
`timescale 1ns/1ps
module adc_result_byte_lock_bank_test;
  import arbl_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0, vld = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] res [4] = '{default: 16'h0};
  logic [4:0]  redundant_channel_select;
  logic [11:0] hi [4] = '{IDX_GIN8_HI, IDX_DIE_MAIN_HI, IDX_DIE_AUX_HI,
                          IDX_CELL_HI};
  int          n_errors = 0, samples_checked = 0;
  arbl_bank arbl_bank_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .general_input_eight_valid(vld[0]), .general_input_eight_result(res[0]),
    .die_temp_main_valid(vld[1]), .die_temp_main_result(res[1]),
    .die_temp_aux_valid(vld[2]), .die_temp_aux_result(res[2]),
    .redundant_cell_voltage_valid(vld[3]),
    .redundant_cell_voltage_result(res[3]),
    .redundant_channel_select(redundant_channel_select));
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (tb !== 1'b1) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] i, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (tr !== 1'b1) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic push(input int k, input logic [15:0] v);
    @(posedge aclk);
    res[k] <= v;
    vld[k] <= 1'b1;
    @(posedge aclk);
    vld[k] <= 1'b0;
  endtask
  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      rd(hi[k], 32'h80, RESP_OKAY);
      rd(hi[k] + 12'h1, 32'h0, RESP_OKAY);
    end
    rd(IDX_CTRL, 32'h0, RESP_OKAY);
  endtask
  task automatic t_lock();
    logic [15:0] a, b;
    wr(IDX_CTRL, 32'h1, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      a = 16'hF120 + 16'(k);
      b = 16'h0A50 + 16'(k);
      push(k, a);
      rd(hi[k], {24'h0, a[15:8]}, RESP_OKAY);
      rd(IDX_CTRL, 32'h1 | (32'h100 << k),
         RESP_OKAY);
      push(k, b);
      wr(hi[k] + 12'h1, 32'hFF, RESP_OKAY);
      rd(hi[k] + 12'h1, {24'h0, a[7:0]}, RESP_OKAY);
      rd(hi[k] + 12'h1, {24'h0, b[7:0]}, RESP_OKAY);
      rd(hi[k], {24'h0, b[15:8]}, RESP_OKAY);
      rd(hi[k] + 12'h1, {24'h0, b[7:0]}, RESP_OKAY);
    end
  endtask
  task automatic t_select();
    wr(IDX_CTRL, 32'h0, RESP_OKAY);
    push(3, 16'h1111);
    rd(IDX_CELL_HI, 32'h0A, RESP_OKAY);
    wr(IDX_CTRL, 32'h7, RESP_OKAY);
    chk({27'h0, redundant_channel_select}, 32'h7);
    push(3, 16'h2222);
    rd(IDX_CELL_HI, 32'h0A, RESP_OKAY);
    wr(IDX_CTRL, 32'h6, RESP_OKAY);
    push(3, 16'h8001);
    rd(IDX_CELL_HI, 32'h80, RESP_OKAY);
    rd(IDX_CELL_LO, 32'h01, RESP_OKAY);
    rd(12'h5A0, 32'h0, RESP_DECERR);
    wr(12'h5A0, 32'h1, RESP_DECERR);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_lock();
    t_select();
    stop_test();
  end
endmodule
